// ### rtl/glt_pkg.sv
// shared constants and types for the gpio lookup-table block
// assumes a single 250 MHz clock domain and a 2-wire serial register port
package glt_pkg;

    // =====================================================================
    // register map
    localparam logic [7:0] ADDR_HIGH_A_LUT = 8'h25;
    localparam logic [7:0] ADDR_LOW_B_LUT = 8'h26;
    localparam logic [7:0] ADDR_LOW_A_LUT = 8'h27;
    localparam logic [7:0] RST_LUT = 8'h00;

    // =====================================================================
    // gpio line positions
    localparam int LOW_A_SEL_LSB = 0;
    localparam int LOW_A_OUT_BIT = 3;
    localparam int HIGH_A_SEL_LSB = 4;
    localparam int HIGH_A_OUT_BIT = 7;
    localparam int LOW_B_SEL_LSB = 8;
    localparam int LOW_B_OUT_BIT = 11;

    // =====================================================================
    // serial port framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;

    typedef enum logic [8:0] {
        ST_IDLE     = 9'b000000001,
        ST_ADDR     = 9'b000000010,
        ST_ADDR_ACK = 9'b000000100,
        ST_PTR      = 9'b000001000,
        ST_PTR_ACK  = 9'b000010000,
        ST_WR       = 9'b000100000,
        ST_WR_ACK   = 9'b001000000,
        ST_RD       = 9'b010000000,
        ST_RD_ACK   = 9'b100000000
    } glt_state_e;

    // line events seen on the synchronised serial pins
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } glt_bus_ev_s;

endpackage : glt_pkg

// ### rtl/glt_lut_block.sv
// three-input to one-output lookup tables for gpio lines 3, 7 and 11,
// with their truth tables reached over the 2-wire serial register port.
// assumes: mode selects come from the mode registers on the same clock;
// pins (scl, sda, gpio) are asynchronous and are synchronised here.
`timescale 1ns/1ps
module glt_lut_block
    import glt_pkg::*;
#(
    // 7-bit serial slave address; value is arbitrary
    parameter logic [6:0] DEV_ADDR = 7'h20,
    // mode field code meaning three-to-one lookup
    parameter logic [1:0] MODE_3TO1 = 2'h1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // serial register port, sda open drain
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // mode selects
    input wire logic [1:0] low_a_logic_mode_sel,
    input wire logic [1:0] low_b_logic_mode_sel,
    input wire logic [1:0] high_a_logic_mode_sel,
    // gpio lines
    input wire logic [15:0] gpio_in,
    output logic [15:0] gpio_out,
    output logic [15:0] gpio_oe_n
);

    // =====================================================================
    // pin synchronisers
    logic [15:0] gpio_meta;
    logic [15:0] gpio_sync;
    logic [1:0] ser_meta;
    logic [1:0] ser_sync;
    logic [1:0] ser_prev;
    glt_bus_ev_s ev;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gpio_meta <= 16'h0000;
            gpio_sync <= 16'h0000;
        end else begin
            gpio_meta <= gpio_in;
            gpio_sync <= gpio_meta;
        end
    end

    // idle bus is high; reset to high so no false start is seen
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ser_meta <= 2'h3;
            ser_sync <= 2'h3;
            ser_prev <= 2'h3;
        end else begin
            ser_meta <= {scl, sda_in};
            ser_sync <= ser_meta;
            ser_prev <= ser_sync;
        end
    end

    // bit 1 is scl, bit 0 is sda
    always_comb begin
        ev.rise = ser_sync[1] && !ser_prev[1];
        ev.fall = !ser_sync[1] && ser_prev[1];
        ev.start = ser_sync[1] && ser_prev[1] && ser_prev[0] && !ser_sync[0];
        ev.stop = ser_sync[1] && ser_prev[1] && !ser_prev[0] && ser_sync[0];
    end

    // =====================================================================
    // serial protocol engine
    glt_state_e state;
    glt_state_e next_state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [7:0] next_tx_sh;
    logic [7:0] reg_ptr;
    logic rd_dir;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rd_data;
    logic byte_done;

    logic [7:0] high_a_lut_three_to_one;
    logic [7:0] low_b_lut_three_to_one;
    logic [7:0] low_a_lut_three_to_one;

    assign byte_done = (bit_cnt == BITS_PER_BYTE);
    assign wr_stb = ev.fall && (state == ST_WR) && byte_done;
    // a read byte is fetched when entering or re-entering the read state
    assign rd_stb = ev.fall && (((state == ST_ADDR_ACK) && rd_dir) || (state == ST_RD_ACK));

    always_comb begin
        if (reg_ptr == ADDR_HIGH_A_LUT) begin
            rd_data = high_a_lut_three_to_one;
        end else if (reg_ptr == ADDR_LOW_B_LUT) begin
            rd_data = low_b_lut_three_to_one;
        end else if (reg_ptr == ADDR_LOW_A_LUT) begin
            rd_data = low_a_lut_three_to_one;
        end else begin
            rd_data = 8'h00;
        end
    end

    always_comb begin
        next_state = state;
        next_tx_sh = tx_sh;
        if (ev.start) begin
            next_state = ST_ADDR;
        end else if (ev.stop) begin
            next_state = ST_IDLE;
        end else if (ev.rise) begin
            // master nack ends a read burst
            if ((state == ST_RD_ACK) && ser_sync[0]) begin
                next_state = ST_IDLE;
            end
        end else if (ev.fall) begin
            case (state)
                ST_ADDR: begin
                    if (byte_done) begin
                        next_state = (rx_sh[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    next_state = rd_dir ? ST_RD : ST_PTR;
                    next_tx_sh = rd_data;
                end
                ST_PTR: begin
                    if (byte_done) begin
                        next_state = ST_PTR_ACK;
                    end
                end
                ST_PTR_ACK: begin
                    next_state = ST_WR;
                end
                ST_WR: begin
                    if (byte_done) begin
                        next_state = ST_WR_ACK;
                    end
                end
                ST_WR_ACK: begin
                    next_state = ST_WR;
                end
                ST_RD: begin
                    if (byte_done) begin
                        next_state = ST_RD_ACK;
                    end else begin
                        next_tx_sh = {tx_sh[6:0], 1'b0};
                    end
                end
                ST_RD_ACK: begin
                    next_state = ST_RD;
                    next_tx_sh = rd_data;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            tx_sh <= 8'h00;
        end else begin
            state <= next_state;
            tx_sh <= next_tx_sh;
        end
    end

    // bit counter restarts on every state change, counts scl rises
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt <= BIT_CNT_RST;
            rx_sh <= 8'h00;
        end else if (next_state != state || ev.start) begin
            bit_cnt <= BIT_CNT_RST;
        end else if (ev.rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            rx_sh <= {rx_sh[6:0], ser_sync[0]};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_dir <= 1'b0;
        end else if (ev.fall && (state == ST_ADDR) && byte_done) begin
            rd_dir <= rx_sh[0];
        end
    end

    // pointer auto-increments after every byte written or fetched
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_ptr <= 8'h00;
        end else if (ev.fall && (state == ST_PTR) && byte_done) begin
            reg_ptr <= rx_sh;
        end else if (wr_stb || rd_stb) begin
            reg_ptr <= reg_ptr + 8'h01;
        end
    end

    // open drain: only ever pull low, released otherwise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sda_oe_n <= 1'b1;
        end else begin
            sda_oe_n <= !((next_state == ST_ADDR_ACK) || (next_state == ST_PTR_ACK)
                || (next_state == ST_WR_ACK) || ((next_state == ST_RD) && !next_tx_sh[7]));
        end
    end

    assign sda_out = 1'b0;

    // =====================================================================
    // truth-table registers; unmapped writes are dropped
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            high_a_lut_three_to_one <= RST_LUT;
            low_b_lut_three_to_one <= RST_LUT;
            low_a_lut_three_to_one <= RST_LUT;
        end else if (wr_stb) begin
            if (reg_ptr == ADDR_HIGH_A_LUT) begin
                high_a_lut_three_to_one <= rx_sh;
            end else if (reg_ptr == ADDR_LOW_B_LUT) begin
                low_b_lut_three_to_one <= rx_sh;
            end else if (reg_ptr == ADDR_LOW_A_LUT) begin
                low_a_lut_three_to_one <= rx_sh;
            end
        end
    end

    // =====================================================================
    // lookups, re-evaluated every cycle
    logic [2:0] low_a_idx;
    logic [2:0] high_a_idx;
    logic [2:0] low_b_idx;

    assign low_a_idx = gpio_sync[LOW_A_SEL_LSB +: 3];
    assign high_a_idx = gpio_sync[HIGH_A_SEL_LSB +: 3];
    assign low_b_idx = gpio_sync[LOW_B_SEL_LSB +: 3];

    // lines not owned by an active lookup stay released for the gpio core
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gpio_out <= 16'h0000;
            gpio_oe_n <= 16'hFFFF;
        end else begin
            gpio_out <= 16'h0000;
            gpio_oe_n <= 16'hFFFF;
            if (low_a_logic_mode_sel == MODE_3TO1) begin
                gpio_out[LOW_A_OUT_BIT] <= low_a_lut_three_to_one[low_a_idx];
                gpio_oe_n[LOW_A_OUT_BIT] <= 1'b0;
            end
            if (high_a_logic_mode_sel == MODE_3TO1) begin
                gpio_out[HIGH_A_OUT_BIT] <= high_a_lut_three_to_one[high_a_idx];
                gpio_oe_n[HIGH_A_OUT_BIT] <= 1'b0;
            end
            if (low_b_logic_mode_sel == MODE_3TO1) begin
                gpio_out[LOW_B_OUT_BIT] <= low_b_lut_three_to_one[low_b_idx];
                gpio_oe_n[LOW_B_OUT_BIT] <= 1'b0;
            end
        end
    end

endmodule : glt_lut_block

// ### tb/glt_pin_model.sv
// pin-side model: outside drivers on the gpio lines and the sda pull-up
// assumes the device drives only lines whose oe_n bit is low
`timescale 1ns/1ps
module glt_pin_model (
    // bench side
    input wire logic [15:0] drv,
    input wire logic sda_m,
    // device side
    input wire logic sda_oe_n,
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] gpio_oe_n,
    output logic [15:0] gpio_in,
    output logic sda_in
);
    // =========================================================
    // outside drivers step back where the device drives, so those lines read back
    assign gpio_in = (drv & gpio_oe_n) | (gpio_out & ~gpio_oe_n);
    // pulled up: low if either side pulls
    assign sda_in = sda_m & sda_oe_n;
endmodule : glt_pin_model

// ### tb/glt_lut_block_properties.sv
// port checks for the gpio lookup block
// assumes one clock and the asynchronous active-low reset
`timescale 1ns/1ps
module glt_lut_block_properties
    import glt_pkg::*;
#(
    parameter logic [1:0] MODE_3TO1 = 2'h1
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [1:0] low_a_logic_mode_sel,
    input wire logic [1:0] low_b_logic_mode_sel,
    input wire logic [1:0] high_a_logic_mode_sel,
    input wire logic [15:0] gpio_in,
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] gpio_oe_n
);
    // =========================================================
    // skip the first edges after reset, where $past still sees reset-time inputs
    logic [1:0] up_cnt;
    logic up;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    assign up = (up_cnt == 2'h3);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_sda_out_low; sda_out == 1'b0; endproperty
    a_sda_out_low: assert property (p_sda_out_low) else $error("sda data not low");
    property p_oe_low_b;
        up |-> gpio_oe_n[11] == ($past(low_b_logic_mode_sel) != MODE_3TO1);
    endproperty
    a_oe_low_b: assert property (p_oe_low_b) else $error("line 11 enable wrong");
    property p_oe_low_a;
        up |-> gpio_oe_n[3] == ($past(low_a_logic_mode_sel) != MODE_3TO1);
    endproperty
    a_oe_low_a: assert property (p_oe_low_a) else $error("line 3 enable wrong");
    property p_oe_high_a;
        up |-> gpio_oe_n[7] == ($past(high_a_logic_mode_sel) != MODE_3TO1);
    endproperty
    a_oe_high_a: assert property (p_oe_high_a) else $error("line 7 enable wrong");
    property p_off_quiet; (gpio_out & gpio_oe_n) == 16'h0000; endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("undriven line high");
    property p_unused; (gpio_oe_n | 16'h0888) == 16'hFFFF; endproperty
    a_unused: assert property (p_unused) else $error("stray line driven");
    property p_hold;
        (up && $stable({gpio_in, scl, sda_in, low_a_logic_mode_sel, low_b_logic_mode_sel,
            high_a_logic_mode_sel}))[*7] |=> $stable(gpio_out);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved with inputs quiet");
    property p_ack_low; $fell(sda_oe_n) |-> !scl; endproperty
    a_ack_low: assert property (p_ack_low) else $error("sda pulled while scl high");
    c_line11: cover property (!gpio_oe_n[11] && gpio_out[11]);
    c_line3: cover property (!gpio_oe_n[3] && gpio_out[3]);
    c_ack: cover property ($fell(sda_oe_n));
endmodule : glt_lut_block_properties

bind glt_lut_block glt_lut_block_properties #(.MODE_3TO1(MODE_3TO1)) chk_u (.mclk(mclk),
    .arst_n(arst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .low_a_logic_mode_sel(low_a_logic_mode_sel), .low_b_logic_mode_sel(low_b_logic_mode_sel),
    .high_a_logic_mode_sel(high_a_logic_mode_sel), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n));

// ### tb/tb.sv
// testbench for the gpio lookup block
// assumes the pin model closes the sda and gpio loops
`timescale 1ns/1ps
module tb
    import glt_pkg::*;
;
    // =========================================================
    localparam logic [1:0] MODE_ON = 2'h1;
    logic mclk = 1'b0, arst_n = 1'b0, scl = 1'b1, sda_m = 1'b1, sda_in, sda_out, sda_oe_n;
    logic [1:0] mode_a = MODE_ON, mode_b = MODE_ON, mode_h = MODE_ON;
    logic [15:0] drv = 16'h0000, gpio_in, gpio_out, gpio_oe_n;
    int num_errors = 0;
    int samples_checked = 0;
    glt_lut_block #(.MODE_3TO1(MODE_ON)) dut_u (.mclk(mclk), .arst_n(arst_n), .scl(scl),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .low_a_logic_mode_sel(mode_a),
        .low_b_logic_mode_sel(mode_b), .high_a_logic_mode_sel(mode_h), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
    glt_pin_model pins_u (.drv(drv), .sda_m(sda_m), .sda_oe_n(sda_oe_n), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in), .sda_in(sda_in));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // each scl phase lasts 8 mclk, above the 4 the port needs
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_m = b[i];
            cyc(8);
            scl = 1'b1;
            cyc(8);
            scl = 1'b0;
        end
        sda_m = 1'b1;
        cyc(8);
        scl = 1'b1;
        cyc(4);
        check({15'h0000, sda_in}, 16'h0000);
        cyc(4);
        scl = 1'b0;
    endtask : send_byte
    // start from idle, or repeated start when scl is low after an ack
    task automatic bus_start;
        sda_m = 1'b1;
        cyc(8);
        scl = 1'b1;
        cyc(8);
        sda_m = 1'b0;
        cyc(8);
        scl = 1'b0;
    endtask : bus_start
    task automatic bus_stop;
        sda_m = 1'b0;
        cyc(8);
        scl = 1'b1;
        cyc(8);
        sda_m = 1'b1;
        cyc(8);
    endtask : bus_stop
    // sda is released first; the device puts each bit out shortly after scl falls
    task automatic recv_byte(input logic last, output logic [7:0] b);
        sda_m = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            cyc(8);
            scl = 1'b1;
            cyc(4);
            b[i] = sda_in;
            cyc(4);
            scl = 1'b0;
        end
        sda_m = last;
        cyc(8);
        scl = 1'b1;
        cyc(8);
        scl = 1'b0;
    endtask : recv_byte
    // first byte lands on the unmapped 0x24 and is dropped; the pointer then steps on
    task automatic write_tables(input logic [31:0] d);
        bus_start();
        send_byte(8'h40);
        send_byte(ADDR_HIGH_A_LUT - 8'h01);
        for (int i = 3; i >= 0; i--) begin
            send_byte(d[8 * i +: 8]);
        end
        bus_stop();
    endtask : write_tables
    // reads 0x24 (unmapped, reads zero) and the three tables, last byte nacked
    task automatic read_tables(input logic [31:0] exp);
        logic [7:0] b;
        bus_start();
        send_byte(8'h40);
        send_byte(ADDR_HIGH_A_LUT - 8'h01);
        bus_start();
        send_byte(8'h41);
        for (int i = 3; i >= 0; i--) begin
            recv_byte(i == 0, b);
            check({8'h00, b}, {8'h00, exp[8 * i +: 8]});
        end
        bus_stop();
    endtask : read_tables
    // m holds the enables of low-B, high-A and low-A, top bit first; t holds their tables
    // in the same order; each lookup gets a different index so swapped selects show up
    task automatic sweep(input logic [23:0] t, input logic [2:0] m);
        logic [15:0] exp;
        logic [2:0] ia;
        logic [2:0] ih;
        logic [2:0] ib;
        mode_b = m[2] ? MODE_ON : 2'h2;
        mode_h = m[1] ? MODE_ON : 2'h2;
        mode_a = m[0] ? MODE_ON : 2'h0;
        for (int k = 0; k < 8; k++) begin
            ia = k[2:0];
            ih = ~k[2:0];
            ib = k[2:0] ^ 3'h3;
            drv = {5'h00, ib, 1'b0, ih, 1'b0, ia};
            cyc(9);
            exp = {4'h0, m[2] & t[16 + ib], 3'h0, m[1] & t[8 + ih], 3'h0, m[0] & t[ia], 3'h0};
            check(gpio_out, exp);
            check(gpio_oe_n, ~{4'h0, m[2], 3'h0, m[1], 3'h0, m[0], 3'h0});
        end
    endtask : sweep
    initial begin
        cyc(20);
        check(gpio_out, 16'h0000);
        check({14'h0000, sda_out, sda_oe_n}, 16'h0001);
        check(gpio_oe_n, 16'hFFFF);
        arst_n = 1'b1;
        cyc(4);
        sweep(24'h000000, 3'b111);
        // 0x25 high-A gets A5, 0x26 low-B gets 3C, 0x27 low-A gets 96
        write_tables(32'hFF_A5_3C_96);
        read_tables(32'h00_A5_3C_96);
        sweep(24'h3C_A5_96, 3'b111);
        sweep(24'h3C_A5_96, 3'b011);
        sweep(24'h3C_A5_96, 3'b101);
        sweep(24'h3C_A5_96, 3'b110);
        sweep(24'h3C_A5_96, 3'b000);
        arst_n = 1'b0;
        cyc(2);
        check(gpio_oe_n, 16'hFFFF);
        arst_n = 1'b1;
        cyc(4);
        read_tables(32'h0000_0000);
        sweep(24'h000000, 3'b111);
        give_verdict();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end
endmodule : tb
